//--- hw/adc_status_mode_regs.sv
// Summary of operation
// - identity register is read-only: device code high nibble, revision low.
// - check error flag sets on bad command, host clears by writing zero.
// - secondary error summary is read-only, high while amplifier errors logged.
// - reference alarm bit resampled at each new conversion start.
// - new data flag high when held result is unread, cleared by data read.
// - clock source bit read-only: zero internal, one external.
// - reset flag is one after reset; host clears by writing zero.
// - main status at address one, resets to 01h.
// - rate select bits 7:3; codes 10000 upward mean the top rate.
// - filter select bits 2:0; FIR default, some codes reserved.
// - at 14.4 kSPS and above the filter is sinc5 regardless of bits.
// - rate and filter register at address two, resets to 24h.
// - conversion control at address three, resets 01h; mode and delay fields.
// - identity register at address zero.
// - mode bit zero runs continuous conversions, one runs single shots.
// - a changing write to either mode register restarts conversion.
`timescale 1ns/10ps
`default_nettype none
`include "adc_regs_cfg.svh"
module adc_status_mode_regs #(
  parameter logic [3:0] DEVICE_CODE = 4'hA, // arbitrary value
  parameter logic [3:0] REVISION_CODE = 4'h1, // arbitrary value
  parameter int DELAY_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register access from the command engine
  input wire logic chip_select_converter_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  // events from the converter core
  input wire logic crc_error,
  input wire logic amp_error_logged,
  input wire logic reference_low_alarm,
  input wire logic ext_clock_sel,
  input wire logic conversion_done,
  input wire logic data_read,
  input wire logic start_pulse,
  input wire logic tick_en,
  // register read data
  output logic [7:0] reg_rdata,
  // to the converter core
  output logic [4:0] rate_select,
  output logic [2:0] filter_mode,
  output logic conversion_mode_select,
  output logic [3:0] start_delay,
  output logic conv_restart,
  output logic conv_start,
  output logic conv_active,
  output logic new_data_flag
);
  typedef struct packed {
    logic check_error;
    logic reserved7;
    logic reserved5;
    logic secondary_error;
    logic ref_alarm;
    logic new_data;
    logic clock_source;
    logic reset_seen;
    logic [7:0] rate_filter;
    logic [7:0] conv_ctrl;
    logic [7:0] rdata;
    logic restart;
    logic start;
    adc_regs_pkg::conv_state_e state;
  } regs_s;
  regs_s r_q, r_d;
  logic delay_done;

  conv_delay_timer #(
    .CNT_W(DELAY_W)
  ) u_delay (
    .clk(clk),
    .sys_rst(sys_rst),
    .tick_en(tick_en),
    .start(r_q.start),
    .delay_code(r_q.conv_ctrl[`DELAY_HI:`DELAY_LO]),
    .done(delay_done)
  );

  function automatic logic [2:0] eff_filter(input logic [7:0] cfg);
    logic [4:0] rate;
    adc_regs_pkg::filter_mode_e m;
    rate = cfg[`RATE_HI:`RATE_LO];
    case (cfg[`FILTER_HI:`FILTER_LO])
      3'h0: m = adc_regs_pkg::filt_sinc1;
      3'h2: m = adc_regs_pkg::filt_sinc3;
      3'h3: m = adc_regs_pkg::filt_sinc4;
      3'h4: m = adc_regs_pkg::filt_fir;
      default: m = adc_regs_pkg::filt_reserved;
    endcase
    if (rate >= `RATE_FAST_MIN) begin
      m = adc_regs_pkg::filt_sinc5;
    end
    return 3'(m);
  endfunction

  function automatic logic [4:0] eff_rate(input logic [7:0] cfg);
    logic [4:0] rate;
    rate = cfg[`RATE_HI:`RATE_LO];
    // every code from the clamp point upward is the same top rate
    if (rate >= `RATE_CLAMP_MIN) begin
      rate = `RATE_CLAMP_MIN;
    end
    return rate;
  endfunction

  function automatic logic [7:0] status_byte(input regs_s s);
    logic [7:0] b;
    b = 8'h00;
    b[`BIT_RESERVED_HI] = s.reserved7;
    b[`BIT_RESERVED_LO] = s.reserved5;
    b[`BIT_CHECK_ERROR] = s.check_error;
    b[`BIT_SECONDARY_ERROR] = s.secondary_error;
    b[`BIT_REF_ALARM] = s.ref_alarm;
    b[`BIT_NEW_DATA] = s.new_data;
    b[`BIT_CLOCK_SOURCE] = s.clock_source;
    b[`BIT_RESET_SEEN] = s.reset_seen;
    return b;
  endfunction

  logic wr_ok;
  logic rd_ok;
  logic new_conv;
  assign wr_ok = reg_wr && !chip_select_converter_n;
  assign rd_ok = reg_rd && !chip_select_converter_n;
  assign new_conv = r_q.start;

  always_comb begin
    r_d = r_q;
    r_d.restart = 1'b0;
    r_d.start = 1'b0;
    r_d.secondary_error = amp_error_logged;
    r_d.clock_source = ext_clock_sel;
    if (new_conv) begin
      r_d.ref_alarm = reference_low_alarm;
    end
    if (wr_ok) begin
      case (reg_addr)
        `ADDR_MAIN_STATUS: begin
          r_d.reserved7 = reg_wdata[`BIT_RESERVED_HI];
          r_d.reserved5 = reg_wdata[`BIT_RESERVED_LO];
          if (!reg_wdata[`BIT_CHECK_ERROR]) begin
            r_d.check_error = 1'b0;
          end
          if (!reg_wdata[`BIT_RESET_SEEN]) begin
            r_d.reset_seen = 1'b0;
          end
        end
        `ADDR_RATE_FILTER_CONFIG: begin
          r_d.rate_filter = reg_wdata;
          r_d.restart = reg_wdata != r_q.rate_filter;
        end
        `ADDR_CONVERSION_CONTROL: begin
          r_d.conv_ctrl = reg_wdata;
          r_d.restart = reg_wdata != r_q.conv_ctrl;
        end
        default: begin
        end
      endcase
    end
    // hardware sets come last so they win over a same-cycle clear
    if (crc_error && !chip_select_converter_n) begin
      r_d.check_error = 1'b1;
    end
    if (data_read) begin
      r_d.new_data = 1'b0;
    end
    if (conversion_done) begin
      r_d.new_data = 1'b1;
    end
    if (rd_ok) begin
      case (reg_addr)
        `ADDR_DEVICE_IDENTITY: r_d.rdata = {DEVICE_CODE, REVISION_CODE};
        `ADDR_MAIN_STATUS: r_d.rdata = status_byte(r_q);
        `ADDR_RATE_FILTER_CONFIG: r_d.rdata = r_q.rate_filter;
        `ADDR_CONVERSION_CONTROL: r_d.rdata = r_q.conv_ctrl;
        default: r_d.rdata = 8'h00;
      endcase
    end
    case (r_q.state)
      adc_regs_pkg::conv_idle: begin
        if (start_pulse || r_d.restart) begin
          r_d.start = 1'b1;
          r_d.state = adc_regs_pkg::conv_delay;
        end
      end
      adc_regs_pkg::conv_delay: begin
        if (r_d.restart) begin
          r_d.start = 1'b1;
        end else if (delay_done) begin
          r_d.state = adc_regs_pkg::conv_run;
        end
      end
      adc_regs_pkg::conv_run: begin
        if (r_d.restart) begin
          r_d.start = 1'b1;
          r_d.state = adc_regs_pkg::conv_delay;
        end else if (conversion_done) begin
          if (r_q.conv_ctrl[`BIT_CONV_MODE]) begin
            r_d.state = adc_regs_pkg::conv_idle;
          end else begin
            r_d.start = 1'b1;
            r_d.state = adc_regs_pkg::conv_delay;
          end
        end
      end
      default: r_d.state = adc_regs_pkg::conv_idle;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      r_q <= '0;
      r_q.reset_seen <= 1'b1;
      r_q.rate_filter <= `RST_RATE_FILTER_CONFIG;
      r_q.conv_ctrl <= `RST_CONVERSION_CONTROL;
      r_q.state <= adc_regs_pkg::conv_idle;
    end else begin
      r_q <= r_d;
    end
  end

  // registered copies so every output leaves a flip-flop
  logic [4:0] rate_q;
  logic [2:0] filt_q;
  logic [3:0] delay_q;
  logic mode_q;
  logic active_q;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rate_q <= `RST_RATE_SELECT;
      filt_q <= `RST_FILTER_MODE;
      delay_q <= `RST_START_DELAY;
      mode_q <= 1'b0;
      active_q <= 1'b0;
    end else begin
      rate_q <= eff_rate(r_q.rate_filter);
      filt_q <= eff_filter(r_q.rate_filter);
      delay_q <= r_q.conv_ctrl[`DELAY_HI:`DELAY_LO];
      mode_q <= r_q.conv_ctrl[`BIT_CONV_MODE];
      active_q <= r_q.state != adc_regs_pkg::conv_idle;
    end
  end

  assign reg_rdata = r_q.rdata;
  assign rate_select = rate_q;
  assign filter_mode = filt_q;
  assign start_delay = delay_q;
  assign conversion_mode_select = mode_q;
  assign conv_active = active_q;
  assign conv_restart = r_q.restart;
  assign conv_start = r_q.start;
  assign new_data_flag = r_q.new_data;
endmodule
`default_nettype wire

//--- hw/conv_delay_timer.sv
`timescale 1ns/10ps
`default_nettype none
`include "adc_regs_cfg.svh"
// start-of-conversion delay counter, one enable per tick
module conv_delay_timer #(
  parameter int CNT_W = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // control
  input wire logic tick_en,
  input wire logic start,
  input wire logic [3:0] delay_code,
  // status
  output logic done
);
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic busy;
    logic done;
  } timer_s;
  timer_s st_q, st_d;

  // delay grows roughly as a power of two of the code
  function automatic logic [CNT_W-1:0] load_of(input logic [3:0] code);
    logic [CNT_W-1:0] v;
    v = '0;
    v[code] = 1'b1;
    return v;
  endfunction

  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    if (start) begin
      st_d.cnt = load_of(delay_code);
      st_d.busy = 1'b1;
    end else if (st_q.busy && tick_en) begin
      if (st_q.cnt <= CNT_W'(1)) begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt - CNT_W'(1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign done = st_q.done;
endmodule
`default_nettype wire

//--- inc/adc_regs_cfg.svh
`ifndef ADC_REGS_CFG_SVH
`define ADC_REGS_CFG_SVH
`define ADDR_DEVICE_IDENTITY 8'h00
`define ADDR_MAIN_STATUS 8'h01
`define ADDR_RATE_FILTER_CONFIG 8'h02
`define ADDR_CONVERSION_CONTROL 8'h03
`define RST_MAIN_STATUS 8'h01
`define RST_RATE_FILTER_CONFIG 8'h24
`define RST_CONVERSION_CONTROL 8'h01
`define BIT_CHECK_ERROR 6
`define BIT_SECONDARY_ERROR 4
`define BIT_REF_ALARM 3
`define BIT_NEW_DATA 2
`define BIT_CLOCK_SOURCE 1
`define BIT_RESET_SEEN 0
`define BIT_RESERVED_HI 7
`define BIT_RESERVED_LO 5
`define RST_RATE_SELECT 5'h04
`define RST_FILTER_MODE 3'h3
`define RST_START_DELAY 4'h1
`define BIT_CONV_MODE 4
`define RATE_HI 7
`define RATE_LO 3
`define FILTER_HI 2
`define FILTER_LO 0
`define DELAY_HI 3
`define DELAY_LO 0
`define RATE_FAST_MIN 5'h0D
`define RATE_CLAMP_MIN 5'h10
`define RATE_TOP 5'h0F
`define NUM_REGS 4
`endif

//--- inc/adc_regs_pkg.sv
package adc_regs_pkg;
  typedef enum logic [2:0] {
    filt_sinc1,
    filt_sinc3,
    filt_sinc4,
    filt_fir,
    filt_sinc5,
    filt_reserved
  } filter_mode_e;
  typedef enum logic [1:0] {
    conv_idle,
    conv_delay,
    conv_run
  } conv_state_e;
endpackage

//--- verif/adc_regs_props.sv
`timescale 1ns/10ps
`default_nettype none
module adc_regs_props #(
  parameter logic [3:0] DEVICE_CODE = 4'hA
) (
  // clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // register access
  input wire logic chip_select_converter_n,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // converter side
  input wire logic conversion_done,
  input wire logic data_read,
  input wire logic [4:0] rate_select,
  input wire logic [2:0] filter_mode,
  input wire logic conv_restart,
  input wire logic conv_start,
  input wire logic new_data_flag
);
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  logic rd_ok;
  logic wr_rate;
  assign rd_ok = reg_rd && !chip_select_converter_n;
  assign wr_rate = reg_wr && !chip_select_converter_n && reg_addr == 8'h02;
  property p_rst; $fell(sys_rst) |-> rate_select == 5'h04 && filter_mode == 3'h3; endproperty
  a_rst: assert property (p_rst) else $error("outputs wrong after reset");
  property p_id; rd_ok && reg_addr == 8'h00 |=> reg_rdata[7:4] == DEVICE_CODE; endproperty
  a_id: assert property (p_id) else $error("identity code wrong");
  property p_unmap; rd_ok && reg_addr > 8'h03 |=> reg_rdata == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_clamp; wr_rate && reg_wdata[7:3] >= 5'h10 |-> ##2 rate_select == 5'h10; endproperty
  a_clamp: assert property (p_clamp) else $error("top rate not clamped");
  property p_sinc5; wr_rate && reg_wdata[7:3] >= 5'h0D |-> ##2 filter_mode == 3'h4; endproperty
  a_sinc5: assert property (p_sinc5) else $error("fast rate filter wrong");
  property p_fir;
    wr_rate && reg_wdata == 8'h24 |-> ##2 rate_select == 5'h04 && filter_mode == 3'h3;
  endproperty
  a_fir: assert property (p_fir) else $error("default filter wrong");
  property p_restart; conv_restart |-> $past(reg_wr) && !$past(chip_select_converter_n); endproperty
  a_restart: assert property (p_restart) else $error("restart without write");
  property p_done; conversion_done |-> ##[1:2] new_data_flag; endproperty
  a_done: assert property (p_done) else $error("new data not flagged");
  property p_read; data_read && !conversion_done |-> ##[1:2] !new_data_flag; endproperty
  a_read: assert property (p_read) else $error("new data not cleared");
  c_restart: cover property (conv_restart);
  c_start: cover property (conv_start);
  c_clamp: cover property (wr_rate && reg_wdata[7:3] >= 5'h10);
endmodule
bind adc_status_mode_regs adc_regs_props #(.DEVICE_CODE(DEVICE_CODE)) u_props (.clk, .sys_rst,
  .chip_select_converter_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
  .conversion_done, .data_read, .rate_select, .filter_mode, .conv_restart, .conv_start,
  .new_data_flag);
`default_nettype wire

//--- verif/adc_status_mode_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module adc_status_mode_regs_tb;
  localparam logic [3:0] DEV = 4'hA; // arbitrary value
  localparam logic [3:0] REV = 4'h1; // arbitrary value
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic crc_error = 1'b0;
  logic amp_error_logged = 1'b0;
  logic reference_low_alarm = 1'b0;
  logic ext_clock_sel = 1'b0;
  logic conversion_done = 1'b0;
  logic data_read = 1'b0;
  logic start_pulse = 1'b0;
  logic tick_en = 1'b1;
  wire logic chip_select_converter_n, reg_wr, reg_rd, conversion_mode_select;
  wire logic conv_restart, conv_start, conv_active, new_data_flag;
  wire logic [7:0] reg_addr, reg_wdata, reg_rdata;
  wire logic [4:0] rate_select;
  wire logic [2:0] filter_mode;
  wire logic [3:0] start_delay;
  int n_errors = 0;
  int samples_checked = 0;
  int cyc = 0;
  int n_starts = 0;
  int k;
  logic [7:0] q;
  always #4 clk = ~clk;
  adc_status_mode_regs #(.DEVICE_CODE(DEV), .REVISION_CODE(REV), .DELAY_W(16)) u_dut (
    .clk, .sys_rst, .chip_select_converter_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
    .crc_error, .amp_error_logged, .reference_low_alarm, .ext_clock_sel, .conversion_done,
    .data_read, .start_pulse, .tick_en, .reg_rdata, .rate_select, .filter_mode,
    .conversion_mode_select, .start_delay, .conv_restart, .conv_start, .conv_active,
    .new_data_flag);
  host_model u_host (.clk, .reg_rdata, .chip_select_converter_n, .reg_wr, .reg_rd, .reg_addr,
    .reg_wdata);
  always @(posedge clk) begin
    n_starts <= n_starts + (conv_start === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      end_of_test;
    end
  end
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, s);
      n_errors++;
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    u_host.cmd(1'b0, 1'b1, a, d, q);
  endtask
  task rdc(input logic [7:0] a, input logic [7:0] e);
    u_host.cmd(1'b0, 1'b0, a, 8'h00, q);
    chk("rdata", e, q);
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk);
    #1 s = 1'b1;
    @(posedge clk);
    #1 s = 1'b0;
  endtask
  task wait_from(input int c);
    for (int i = 0; i < 64 && n_starts == c; i++) @(posedge clk);
    #1;
    chk("started", 8'h01, {7'h0, n_starts != c});
  endtask
  task t_reset_values;
    rdc(8'h00, {DEV, REV});
    rdc(8'h01, 8'h01);
    rdc(8'h02, 8'h24);
    rdc(8'h03, 8'h01);
  endtask
  task t_status;
    wr(8'h01, 8'h00);
    amp_error_logged = 1'b1;
    ext_clock_sel = 1'b1;
    fork
      u_host.cmd(1'b0, 1'b0, 8'h05, 8'h00, q);
      pulse(crc_error);
    join
    chk("unmapped", 8'h00, q);
    rdc(8'h01, 8'h52);
    amp_error_logged = 1'b0;
    ext_clock_sel = 1'b0;
    // clearing write and a fresh error in the same cycle: the error must survive
    fork
      wr(8'h01, 8'h00);
      pulse(crc_error);
    join
    rdc(8'h01, 8'h40);
    wr(8'h01, 8'h00);
    pulse(crc_error);
    rdc(8'h01, 8'h00);
  endtask
  task t_rate;
    logic [7:0] wv [7] = '{8'hF3, 8'h6B, 8'h62, 8'h00, 8'h0B, 8'h21, 8'h24};
    logic [4:0] rv [7] = '{5'h10, 5'h0D, 5'h0C, 5'h00, 5'h01, 5'h04, 5'h04};
    logic [2:0] fv [7] = '{3'h4, 3'h4, 3'h1, 3'h0, 3'h2, 3'h5, 3'h3};
    for (int i = 0; i < 7; i++) begin
      wr(8'h02, wv[i]);
      @(posedge clk);
      #1;
      chk("rate", {3'h0, rv[i]}, {3'h0, rate_select});
      chk("filter", {5'h0, fv[i]}, {5'h0, filter_mode});
      rdc(8'h02, wv[i]);
    end
  endtask
  task t_mode;
    wr(8'h03, 8'h13);
    @(posedge clk);
    #1;
    chk("mode", 8'h13, {3'h0, conversion_mode_select, start_delay});
    u_host.cmd(1'b1, 1'b1, 8'h02, 8'hF3, q);
    wr(8'h00, 8'hFF);
    rdc(8'h02, 8'h24);
    rdc(8'h00, {DEV, REV});
    wr(8'h03, 8'h01);
    rdc(8'h03, 8'h01);
  endtask
  task t_conv;
    reference_low_alarm = 1'b1;
    // let the start delay of the last restart run out so the converter is running
    repeat (8) @(posedge clk);
    k = n_starts;
    pulse(conversion_done);
    wait_from(k);
    rdc(8'h01, 8'h0C);
    chk("new data", 8'h01, {7'h0, new_data_flag});
    pulse(data_read);
    rdc(8'h01, 8'h08);
    reference_low_alarm = 1'b0;
    k = n_starts;
    pulse(conversion_done);
    wait_from(k);
    rdc(8'h01, 8'h04);
    wr(8'h03, 8'h11);
    repeat (8) @(posedge clk);
    #1;
    chk("active", 8'h01, {7'h0, conv_active});
    pulse(conversion_done);
    @(posedge clk);
    #1;
    chk("active", 8'h00, {7'h0, conv_active});
  endtask
  task t_second_reset;
    sys_rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 sys_rst = 1'b0;
    rdc(8'h01, 8'h01);
    k = n_starts;
    pulse(start_pulse);
    wait_from(k);
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    #1 sys_rst = 1'b0;
    t_reset_values;
    t_status;
    t_rate;
    t_mode;
    t_conv;
    t_second_reset;
    end_of_test;
  end
endmodule
`default_nettype wire

//--- verif/host_model.sv
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // clock
  input wire logic clk,
  // read data
  input wire logic [7:0] reg_rdata,
  // command lines
  output logic chip_select_converter_n,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    chip_select_converter_n = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h5A;
    reg_wdata = 8'hA5;
  end
  // s is the select level, w picks a write over a read
  task automatic cmd(input logic s, input logic w, input logic [7:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    #1;
    chip_select_converter_n = s;
    reg_wr = w;
    reg_rd = !w;
    reg_addr = a;
    reg_wdata = (a == 8'h01) ? (d & 8'h5F) : d;
    @(posedge clk);
    #1;
    chip_select_converter_n = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // released lines swing so stale values never pass for data
    reg_addr = ~reg_addr;
    reg_wdata = ~reg_wdata;
    q = reg_rdata;
  endtask
endmodule
`default_nettype wire
